// ===== fcw_control_word_interface.sv
// Cyclic fieldbus command interpreter, drive state machine and word routing.
`timescale 1ns/100ps

// Summary of operation
// - Cyclic words are 16 bits, or 32 bits built from two slots.
// - Up to twelve 16-bit words each way; a usable count limits them.
// - Each outgoing slot carries the signal its own selector picks.
// - Each incoming slot is routed to the destination its selector picks.
// - Command word bits drive states; state is returned in the status word.
// - Debug fast mirrors raw command and status words to monitor outputs.
// - References are signed two's complement 16-bit words.
// - A fieldbus reference is used only when fieldbus is the reference source.
// - Debug fast mirrors both raw references to monitor outputs.
// - Each reference is scaled by one of four settings its type picks.
// - Two actual-value words are sent, taken from act1_sig and act2_sig.
// - Debug fast mirrors both actual values sent to monitor outputs.
// - Each actual value is scaled by one of four settings its type picks.
// - Bit 0 low ramps to stop, then ready-to-switch-on; high readies operation.
// - Bit 1 low coasts to stop, then switch-on inhibited.
// - Bit 2 low stops fast, then switch-on inhibited.
// - Bit 3 high enables operation when run enable is active; low inhibits.
// - With run enable from fieldbus, bit 3 is also that run enable.
// - Bit 4 low forces ramp output to zero.
// - Control comes from fieldbus or local inputs per the two locations.
// - Rising bit 7 clears a fault and goes to switch-on inhibited.
// - Bit 10 low ignores command and references except bits 0 to 2.
module fcw_control_word_interface
  import fcw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Cyclic words from the adapter
  input wire logic rx_valid,
  input wire logic [15:0] rx_cmd,
  input wire logic [15:0] rx_ref1,
  input wire logic [15:0] rx_ref2,
  input wire logic [191:0] rx_data,
  // Cyclic words to the adapter
  output logic [15:0] tx_status,
  output logic [15:0] tx_act1,
  output logic [15:0] tx_act2,
  output logic [191:0] tx_data,
  // Configuration
  input wire logic debug_fast,
  input wire logic wide_words,
  input wire logic [3:0] usable_words,
  input wire logic [47:0] in_sel,
  input wire logic [47:0] out_sel,
  input wire logic [63:0] scale_set,
  input wire logic [1:0] ref1_type,
  input wire logic [1:0] ref2_type,
  input wire logic [1:0] act1_type,
  input wire logic [1:0] act2_type,
  input wire logic ref_src_fieldbus,
  input wire logic run_en_from_fieldbus,
  input wire logic reset_from_fieldbus,
  input wire logic loc_from_fieldbus,
  input wire logic external_location_primary_fb,
  input wire logic external_location_secondary_fb,
  // Drive side
  input wire logic [255:0] sig_bank,
  input wire logic [15:0] act1_sig,
  input wire logic [15:0] act2_sig,
  input wire logic run_enable_ext,
  input wire logic zero_speed,
  input wire logic fault_active,
  input wire logic local_sel_secondary,
  input wire logic [4:0] local_cmd,
  output logic [255:0] dest_words,
  output logic [15:0] ref1_scaled,
  output logic [15:0] ref2_scaled,
  output logic ramp_out_zero,
  output logic coast_out,
  output logic fast_stop,
  output logic modulating,
  output logic fault_clear,
  output logic fb_in_control,
  // Debug monitors
  output logic [15:0] mon_cmd,
  output logic [15:0] mon_status,
  output logic [15:0] mon_ref1,
  output logic [15:0] mon_ref2,
  output logic [15:0] mon_act1,
  output logic [15:0] mon_act2
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] fcw_pick(input logic [1:0] typ, input logic [63:0] bank);
    return bank[typ*FCW_WORD_W +: FCW_WORD_W];
  endfunction

  // Signed value times unsigned Q1.15 factor.
  function automatic logic [15:0] fcw_scale(input logic [15:0] v, input logic [15:0] s);
    logic signed [32:0] p;
    p = 33'($signed(v) * $signed({1'b0, s}));
    return p[FCW_FRAC +: FCW_WORD_W];
  endfunction

  // ----------------------------------------------------------------------
  // Effective command word
  // ----------------------------------------------------------------------
  logic [15:0] eff_cmd;
  logic cmd_seen;
  logic reset_bit_q;
  fcw_state_e state;
  fcw_state_e next_state;
  wire logic remote_on = rx_cmd[FCW_B_REMOTE];
  wire logic [15:0] next_eff_cmd = remote_on ? rx_cmd :
                                   {eff_cmd[15:FCW_ALWAYS_W], rx_cmd[FCW_ALWAYS_W-1:0]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eff_cmd <= FCW_CMD_RST;
      cmd_seen <= 1'b0;
    end else if (rx_valid) begin
      eff_cmd <= next_eff_cmd;
      cmd_seen <= 1'b1;
    end
  end

  // Location chooses which source owns bits 3 and 4.
  wire logic sel_secondary = loc_from_fieldbus ? eff_cmd[FCW_B_EXT_LOC] : local_sel_secondary;
  wire logic loc_fb = sel_secondary ? external_location_secondary_fb
                                    : external_location_primary_fb;
  wire logic ramp_stop_bit = eff_cmd[FCW_B_RAMP_STOP];
  wire logic coast_stop_bit = eff_cmd[FCW_B_COAST_STOP];
  wire logic emergency_stop_bit = eff_cmd[FCW_B_EMERG_STOP];
  wire logic run_bit = loc_fb ? eff_cmd[FCW_B_RUN] : local_cmd[FCW_B_RUN];
  wire logic ramp_bit = loc_fb ? eff_cmd[FCW_B_RAMP_OUT] : local_cmd[FCW_B_RAMP_OUT];
  wire logic run_enable = run_en_from_fieldbus ? run_bit : run_enable_ext;
  wire logic reset_edge = eff_cmd[FCW_B_RESET] & ~reset_bit_q;
  wire logic reset_ok = reset_edge & reset_from_fieldbus & loc_fb;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_bit_q <= 1'b0;
    end else begin
      reset_bit_q <= eff_cmd[FCW_B_RESET];
    end
  end

  // ----------------------------------------------------------------------
  // Drive state machine
  // ----------------------------------------------------------------------
  wire logic running = (state == FCW_READY_RUN) || (state == FCW_OP_ENABLED) ||
                       (state == FCW_RAMP_STOP);

  always_comb begin
    next_state = state;
    case (state)
      FCW_NOT_READY: begin
        if (cmd_seen) next_state = FCW_INHIBITED;
      end
      FCW_FAULT: begin
        if (reset_ok) next_state = FCW_INHIBITED;
      end
      FCW_COAST_STOP, FCW_EMERG_STOP: begin
        if (zero_speed) next_state = FCW_INHIBITED;
      end
      FCW_INHIBITED: begin
        if (!ramp_stop_bit && coast_stop_bit && emergency_stop_bit) begin
          next_state = FCW_READY_ON;
        end
      end
      FCW_READY_ON: begin
        if (ramp_stop_bit) next_state = FCW_READY_RUN;
      end
      FCW_READY_RUN: begin
        if (!ramp_stop_bit) next_state = FCW_READY_ON;
        else if (run_bit && run_enable) next_state = FCW_OP_ENABLED;
      end
      FCW_OP_ENABLED: begin
        if (!ramp_stop_bit) next_state = FCW_RAMP_STOP;
        else if (!run_bit || !run_enable) next_state = FCW_READY_RUN;
      end
      FCW_RAMP_STOP: begin
        if (zero_speed) next_state = FCW_READY_ON;
      end
      default: next_state = FCW_NOT_READY;
    endcase
    // Interlocks override the sequence above.
    if (state != FCW_NOT_READY && state != FCW_FAULT) begin
      if (fault_active) begin
        next_state = FCW_FAULT;
      end else if (!coast_stop_bit && state != FCW_COAST_STOP) begin
        next_state = running ? FCW_COAST_STOP : FCW_INHIBITED;
      end else if (!emergency_stop_bit && coast_stop_bit &&
                   state != FCW_EMERG_STOP && state != FCW_COAST_STOP) begin
        next_state = running ? FCW_EMERG_STOP : FCW_INHIBITED;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FCW_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Drive control outputs and status word
  // ----------------------------------------------------------------------
  logic [15:0] next_status;
  always_comb begin
    next_status = FCW_WORD_RST;
    next_status[FCW_S_RDY_ON] = (state == FCW_READY_ON) || running;
    next_status[FCW_S_RDY_RUN] = (state == FCW_READY_RUN) || (state == FCW_OP_ENABLED);
    next_status[FCW_S_RDY_REF] = (state == FCW_OP_ENABLED);
    next_status[FCW_S_TRIPPED] = (state == FCW_FAULT);
    next_status[FCW_S_COAST_OFF] = (state != FCW_COAST_STOP);
    next_status[FCW_S_EMERG_OFF] = (state != FCW_EMERG_STOP);
    next_status[FCW_S_INHIBIT] = (state == FCW_INHIBITED);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_status <= FCW_WORD_RST;
      ramp_out_zero <= 1'b1;
      coast_out <= 1'b0;
      fast_stop <= 1'b0;
      modulating <= 1'b0;
      fault_clear <= 1'b0;
      fb_in_control <= 1'b0;
    end else begin
      tx_status <= next_status;
      ramp_out_zero <= (state != FCW_OP_ENABLED) || !ramp_bit;
      coast_out <= (state == FCW_COAST_STOP);
      fast_stop <= (state == FCW_EMERG_STOP);
      modulating <= (state == FCW_OP_ENABLED) || (state == FCW_RAMP_STOP) ||
                    (state == FCW_EMERG_STOP);
      fault_clear <= (state == FCW_FAULT) && reset_ok;
      fb_in_control <= loc_fb && cmd_seen;
    end
  end

  // ----------------------------------------------------------------------
  // References and actual values
  // ----------------------------------------------------------------------
  wire logic ref_take = rx_valid && remote_on && ref_src_fieldbus;
  wire logic [15:0] scale_r1 = fcw_pick(ref1_type, scale_set);
  wire logic [15:0] scale_r2 = fcw_pick(ref2_type, scale_set);
  wire logic [15:0] scale_a1 = fcw_pick(act1_type, scale_set);
  wire logic [15:0] scale_a2 = fcw_pick(act2_type, scale_set);
  logic [15:0] raw_ref1;
  logic [15:0] raw_ref2;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_ref1 <= FCW_WORD_RST;
      raw_ref2 <= FCW_WORD_RST;
      ref1_scaled <= FCW_WORD_RST;
      ref2_scaled <= FCW_WORD_RST;
    end else if (ref_take) begin
      raw_ref1 <= rx_ref1;
      raw_ref2 <= rx_ref2;
      ref1_scaled <= fcw_scale(rx_ref1, scale_r1);
      ref2_scaled <= fcw_scale(rx_ref2, scale_r2);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_act1 <= FCW_WORD_RST;
      tx_act2 <= FCW_WORD_RST;
    end else begin
      tx_act1 <= fcw_scale(act1_sig, scale_a1);
      tx_act2 <= fcw_scale(act2_sig, scale_a2);
    end
  end

  // ----------------------------------------------------------------------
  // Debug monitors
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_cmd <= FCW_WORD_RST;
      mon_status <= FCW_WORD_RST;
      mon_ref1 <= FCW_WORD_RST;
      mon_ref2 <= FCW_WORD_RST;
      mon_act1 <= FCW_WORD_RST;
      mon_act2 <= FCW_WORD_RST;
    end else if (debug_fast) begin
      if (rx_valid) mon_cmd <= rx_cmd;
      mon_status <= tx_status;
      if (rx_valid) mon_ref1 <= rx_ref1;
      if (rx_valid) mon_ref2 <= rx_ref2;
      mon_act1 <= tx_act1;
      mon_act2 <= tx_act2;
    end
  end

  // ----------------------------------------------------------------------
  // Mapped data slots
  // ----------------------------------------------------------------------
  wire logic [4:0] slot_limit = wide_words ? {usable_words, 1'b0} : {1'b0, usable_words};
  wire logic data_take = rx_valid && remote_on;
  wire logic [191:0] next_tx_data;

  genvar g;
  generate
    for (g = 0; g < FCW_SLOTS; g++) begin : g_slot
      wire logic slot_used = 5'(g) < slot_limit;
      wire logic [3:0] isel = in_sel[g*FCW_SEL_W +: FCW_SEL_W];
      wire logic [15:0] pick = sig_bank[isel*FCW_WORD_W +: FCW_WORD_W];
      assign next_tx_data[g*FCW_WORD_W +: FCW_WORD_W] = slot_used ? pick : FCW_WORD_RST;
    end
  endgenerate

  // Later slots win when two slots name the same destination.
  logic [255:0] next_dest;
  always_comb begin
    next_dest = dest_words;
    for (int i = 0; i < FCW_SLOTS; i++) begin
      if (data_take && 5'(i) < slot_limit) begin
        next_dest[out_sel[i*FCW_SEL_W +: FCW_SEL_W]*FCW_WORD_W +: FCW_WORD_W] =
          rx_data[i*FCW_WORD_W +: FCW_WORD_W];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dest_words <= '0;
      tx_data <= '0;
    end else begin
      dest_words <= next_dest;
      tx_data <= next_tx_data;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_idle_before_cmd: assert property (
    !cmd_seen |-> state == FCW_NOT_READY && !tx_status[FCW_S_RDY_ON])
    else $error("state left not-ready before any command word");
  a_coast_stop_entry: assert property (
    running && !coast_stop_bit && !fault_active |=> state == FCW_COAST_STOP ##1 coast_out)
    else $error("coast stop not entered");
  a_emerg_stop_entry: assert property (
    running && coast_stop_bit && !emergency_stop_bit && !fault_active
      |=> state == FCW_EMERG_STOP)
    else $error("emergency stop not entered");
  a_ramp_stop_exit: assert property (
    state == FCW_RAMP_STOP && zero_speed && coast_stop_bit && emergency_stop_bit &&
      !fault_active |=> state == FCW_READY_ON)
    else $error("ramp stop did not end in ready-to-switch-on");
  a_run_needs_enable: assert property (
    $rose(state == FCW_OP_ENABLED) |-> $past(run_bit) && $past(run_enable))
    else $error("operation enabled without run and run enable");
  a_ramp_zero_out: assert property (
    state == FCW_OP_ENABLED && !ramp_bit |=> ramp_out_zero)
    else $error("ramp output not forced to zero");
  a_debug_gate_mon: assert property (
    !debug_fast |=> $stable(mon_cmd) && $stable(mon_status))
    else $error("monitor changed while debug is off");
  a_fault_clear_edge: assert property (
    state == FCW_FAULT && reset_ok |=> fault_clear && state == FCW_INHIBITED)
    else $error("fault reset edge not honoured");
  a_ignore_remote: assert property (
    rx_valid && !remote_on |=> eff_cmd[15:FCW_ALWAYS_W] == $past(eff_cmd[15:FCW_ALWAYS_W]))
    else $error("upper command bits taken with remote off");
  a_ref_source: assert property (
    !ref_src_fieldbus |=> $stable(ref1_scaled) && $stable(ref2_scaled))
    else $error("reference taken while fieldbus is not the source");

  c_reach_enabled: cover property (state == FCW_READY_RUN ##1 state == FCW_OP_ENABLED);
  c_coast_path: cover property (state == FCW_COAST_STOP ##[1:20] state == FCW_INHIBITED);
  c_fault_reset: cover property (state == FCW_FAULT ##1 state == FCW_INHIBITED);
  c_debug_mirror: cover property (debug_fast && rx_valid);

endmodule // fcw_control_word_interface

// ===== fcw_control_word_interface_tb.sv
// Self-checking bench for the fieldbus command interpreter.
`timescale 1ns/100ps
module fcw_control_word_interface_tb;
  import fcw_pkg::*;
  typedef struct {int due; int k; logic [255:0] v;} fcw_note_s;
  logic clk, rst_b, rx_valid, debug_fast, wide_words, ref_src_fieldbus, run_en_from_fieldbus;
  logic reset_from_fieldbus, loc_from_fieldbus, external_location_primary_fb;
  logic external_location_secondary_fb, run_enable_ext, zero_speed, fault_active;
  logic local_sel_secondary, ramp_out_zero, coast_out, fast_stop, modulating, fault_clear;
  logic fb_in_control, fc_seen;
  logic [1:0] ref1_type, ref2_type, act1_type, act2_type, rt1, rt2;
  logic [3:0] usable_words;
  logic [4:0] local_cmd;
  logic [11:0] f;
  logic [15:0] rx_cmd, rx_ref1, rx_ref2, tx_status, tx_act1, tx_act2, act1_sig, act2_sig;
  logic [15:0] ref1_scaled, ref2_scaled, mon_cmd, mon_status, mon_ref1, mon_ref2, mon_act1;
  logic [15:0] mon_act2, a1, a2, r1, r2, c, er1, er2, em1, em2, ea1, ea2;
  logic [47:0] in_sel, out_sel, isel, osel;
  logic [63:0] scale_set;
  logic [191:0] rx_data, tx_data, dd, td;
  logic [255:0] sig_bank, dest_words, sb, ed;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int lim;
  fcw_note_s notes[$];
  logic [3:0] uw [4] = '{4'hc, 4'h3, 4'h5, 4'h6};

  fcw_master_model i_fcw_master_model (.clk, .rx_valid, .rx_cmd, .rx_ref1, .rx_ref2, .rx_data);
  fcw_control_word_interface i_fcw_control_word_interface (
    .clk, .rst_b, .rx_valid, .rx_cmd, .rx_ref1, .rx_ref2, .rx_data, .tx_status, .tx_act1,
    .tx_act2, .tx_data, .debug_fast, .wide_words, .usable_words, .in_sel, .out_sel, .scale_set,
    .ref1_type, .ref2_type, .act1_type, .act2_type, .ref_src_fieldbus, .run_en_from_fieldbus,
    .reset_from_fieldbus, .loc_from_fieldbus, .external_location_primary_fb,
    .external_location_secondary_fb, .sig_bank, .act1_sig, .act2_sig, .run_enable_ext,
    .zero_speed, .fault_active, .local_sel_secondary, .local_cmd, .dest_words, .ref1_scaled,
    .ref2_scaled, .ramp_out_zero, .coast_out, .fast_stop, .modulating, .fault_clear,
    .fb_in_control, .mon_cmd, .mon_status, .mon_ref1, .mon_ref2, .mon_act1, .mon_act2
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fault_clear === 1'b1) fc_seen <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input int k, input logic [255:0] v);
    notes.push_back('{cyc + 5, k, v});
  endtask

  task automatic note16(input int k, input logic [15:0] v);
    note(k, 256'(v));
  endtask

  // Product is floored, so negative references round toward minus infinity.
  function automatic logic [15:0] scl(input logic [15:0] r, input logic [1:0] t);
    logic signed [33:0] p;
    p = $signed(r) * $signed({1'b0, scale_set[16*t +: 16]});
    return p[30:15];
  endfunction

  function automatic logic [255:0] obs(input int k);
    logic [159:0] w;
    w = {mon_cmd, mon_status, mon_act2, mon_act1, mon_ref2, mon_ref1, tx_act2, tx_act1,
         ref2_scaled, ref1_scaled};
    if (k == 0) return dest_words;
    if (k == 1) return 256'(tx_data);
    return 256'(w[16*(k-2) +: 16]);
  endfunction

  function automatic logic [11:0] flags();
    return {fb_in_control, ramp_out_zero, coast_out, fast_stop, modulating, tx_status[6:0]};
  endfunction

  always @(negedge clk) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      chk(obs(notes[0].k), notes[0].v);
      void'(notes.pop_front());
    end
  end

  task automatic wt(input int k, input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      f = flags();
      if (f[k] === v) break;
    end
    chk(256'(f[k]), 256'(v));
    if (f[k] !== v) tally_and_finish();
  endtask

  task automatic st(input logic [15:0] cm, input int k, input logic v);
    i_fcw_master_model.frame(cm, 16'h0, 16'h0, 192'h0);
    wt(k, v);
  endtask

  task automatic hold(input logic [15:0] cm, input int k, input logic v);
    i_fcw_master_model.frame(cm, 16'h0, 16'h0, 192'h0);
    repeat (8) @(negedge clk);
    f = flags();
    chk(256'(f[k]), 256'(v));
  endtask

  task automatic zdone(input int k, input logic v);
    @(posedge clk);
    zero_speed <= 1'b1;
    wt(k, v);
    @(posedge clk);
    zero_speed <= 1'b0;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    int i;
    int j;
    rst_b = 1'b0;
    {debug_fast, wide_words, ref_src_fieldbus, run_en_from_fieldbus} = 4'b1010;
    {reset_from_fieldbus, loc_from_fieldbus, external_location_primary_fb} = 3'b101;
    {external_location_secondary_fb, run_enable_ext, zero_speed} = 3'b010;
    {fault_active, local_sel_secondary, fc_seen} = 3'b000;
    {ref1_type, ref2_type, act1_type, act2_type, local_cmd} = '0;
    {in_sel, out_sel, sig_bank, act1_sig, act2_sig, ed, er1, er2} = '0;
    usable_words = 4'hc;
    scale_set = 64'h1234_2000_4000_8000;
    void'($urandom(32'hd1ce));
    repeat (8) @(negedge clk);
    chk(256'({tx_status, ramp_out_zero, modulating}), 256'({16'h0, 2'b10}));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(negedge clk);
    chk(256'(tx_status), 256'(16'h0030));
    st(16'h0406, 6, 1'b1);
    wt(0, 1'b1);
    st(16'h041f, 7, 1'b1);
    wt(2, 1'b1);
    wt(10, 1'b0);
    st(16'h040f, 10, 1'b1);
    st(16'h041f, 10, 1'b0);
    st(16'h0417, 2, 1'b0);
    st(16'h041f, 7, 1'b1);
    hold(16'h0007, 7, 1'b1);
    chk(256'(f[10]), 256'(1'b0));
    st(16'h0003, 8, 1'b1);
    wt(5, 1'b0);
    zdone(6, 1'b1);
    st(16'h0406, 0, 1'b1);
    st(16'h041f, 7, 1'b1);
    st(16'h041d, 9, 1'b1);
    wt(4, 1'b0);
    zdone(6, 1'b1);
    st(16'h0406, 0, 1'b1);
    st(16'h041f, 7, 1'b1);
    st(16'h041e, 1, 1'b0);
    zdone(0, 1'b1);
    wt(7, 1'b0);
    @(posedge clk);
    run_enable_ext <= 1'b0;
    hold(16'h041f, 7, 1'b0);
    @(posedge clk);
    run_en_from_fieldbus <= 1'b1;
    wt(7, 1'b1);
    @(posedge clk);
    loc_from_fieldbus <= 1'b1;
    st(16'h0c1f, 11, 1'b0);
    wt(7, 1'b0);
    wt(10, 1'b1);
    @(posedge clk);
    local_cmd <= 5'h18;
    wt(7, 1'b1);
    st(16'h041f, 11, 1'b1);
    @(posedge clk);
    fault_active <= 1'b1;
    wt(3, 1'b1);
    @(posedge clk);
    fault_active <= 1'b0;
    hold(16'h0406, 3, 1'b1);
    st(16'h0486, 3, 1'b0);
    chk(256'(fc_seen), 256'(1'b1));
    wt(0, 1'b1);
    st(16'h041f, 7, 1'b1);
    for (j = 0; j < 4; j++) begin
      for (i = 0; i < 8; i++) begin
        sb[32*i +: 32] = $urandom();
        if (i < 6) dd[32*i +: 32] = $urandom();
      end
      isel = 48'({$urandom(), $urandom()});
      osel = 48'({$urandom(), $urandom()});
      {a1, a2, r1, r2} = {$urandom(), $urandom()};
      rt1 = (j >= 2) ? 2'h1 : 2'h0;
      rt2 = ~rt1;
      @(posedge clk);
      in_sel <= isel;
      out_sel <= osel;
      sig_bank <= sb;
      act1_sig <= a1;
      act2_sig <= a2;
      act1_type <= 2'(j);
      act2_type <= 2'(3 - j);
      ref1_type <= rt1;
      ref2_type <= rt2;
      wide_words <= j[0];
      usable_words <= uw[j];
      ref_src_fieldbus <= (j != 1);
      debug_fast <= (j != 2);
      repeat (3) @(posedge clk);
      c = (j == 3) ? 16'h001f : 16'h041f;
      i_fcw_master_model.frame(c, r1, r2, dd);
      lim = j[0] ? 2 * uw[j] : uw[j];
      if (lim > 12) lim = 12;
      for (i = 0; i < 12; i++) begin
        if (i < lim && j != 3) ed[16*osel[4*i +: 4] +: 16] = dd[16*i +: 16];
        td[16*i +: 16] = (i < lim) ? sb[16*isel[4*i +: 4] +: 16] : 16'h0;
      end
      if (j == 0 || j == 2) {er1, er2} = {r1, r2};
      if (j != 2) {em1, em2, ea1, ea2} = {r1, r2, scl(a1, 2'(j)), scl(a2, 2'(3 - j))};
      note(0, ed);
      note(1, 256'(td));
      note16(2, scl(er1, rt1));
      note16(3, scl(er2, rt2));
      note16(4, scl(a1, 2'(j)));
      note16(5, scl(a2, 2'(3 - j)));
      note16(6, em1);
      note16(7, em2);
      note16(8, ea1);
      note16(9, ea2);
      note16(10, 16'h0037);
      note16(11, (j == 2) ? 16'h041f : c);
      repeat (8) @(posedge clk);
    end
    tally_and_finish();
  end
endmodule // fcw_control_word_interface_tb

// ===== fcw_master_model.sv
// Fieldbus master model that sends cyclic frames to the drive.
`timescale 1ns/100ps
module fcw_master_model (
  // Clock
  input wire logic clk,
  // Cyclic words to the drive
  output logic rx_valid,
  output logic [15:0] rx_cmd,
  output logic [15:0] rx_ref1,
  output logic [15:0] rx_ref2,
  output logic [191:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    {rx_cmd, rx_ref1, rx_ref2, rx_data} = '0;
  end

  // Words are valid for one cycle, then inverted so stale data never looks fresh.
  task automatic frame(input logic [15:0] c, input logic [15:0] r1, input logic [15:0] r2,
                       input logic [191:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_cmd <= c;
    rx_ref1 <= r1;
    rx_ref2 <= r2;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    {rx_cmd, rx_ref1, rx_ref2, rx_data} <= ~{c, r1, r2, d};
  endtask
endmodule // fcw_master_model

// ===== fcw_pkg.sv
// Constants and types shared by the fieldbus control word interface.
package fcw_pkg;

  // ----------------------------------------------------------------------
  // Word geometry
  // ----------------------------------------------------------------------
  localparam int FCW_WORD_W = 16;
  localparam int FCW_SLOTS = 12;
  localparam int FCW_SEL_W = 4;
  localparam int FCW_BANK = 16;
  localparam int FCW_SCALES = 4;
  localparam int FCW_FRAC = 15;

  // ----------------------------------------------------------------------
  // Command word bit positions
  // ----------------------------------------------------------------------
  localparam int FCW_B_RAMP_STOP = 0;
  localparam int FCW_B_COAST_STOP = 1;
  localparam int FCW_B_EMERG_STOP = 2;
  localparam int FCW_B_RUN = 3;
  localparam int FCW_B_RAMP_OUT = 4;
  localparam int FCW_B_RESET = 7;
  localparam int FCW_B_REMOTE = 10;
  localparam int FCW_B_EXT_LOC = 11;
  localparam int FCW_ALWAYS_W = 3;

  // ----------------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------------
  localparam int FCW_S_RDY_ON = 0;
  localparam int FCW_S_RDY_RUN = 1;
  localparam int FCW_S_RDY_REF = 2;
  localparam int FCW_S_TRIPPED = 3;
  localparam int FCW_S_COAST_OFF = 4;
  localparam int FCW_S_EMERG_OFF = 5;
  localparam int FCW_S_INHIBIT = 6;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] FCW_CMD_RST = 16'h0000;
  localparam logic [15:0] FCW_WORD_RST = 16'h0000;

  typedef enum logic [3:0] {
    FCW_NOT_READY,
    FCW_INHIBITED,
    FCW_READY_ON,
    FCW_READY_RUN,
    FCW_OP_ENABLED,
    FCW_RAMP_STOP,
    FCW_COAST_STOP,
    FCW_EMERG_STOP,
    FCW_FAULT
  } fcw_state_e;

endpackage
